// >>> hdl/pmrs_consts.svh
// register offsets, field positions, reset values and timing counts of the
// power supervision and reset sequencer; included by pmrs_axil, pmrs_top and the bench.
`ifndef PMRS_CONSTS_SVH
`define PMRS_CONSTS_SVH

`define PMRS_OFS_CTRL 8'h00
`define PMRS_OFS_MODE 8'h04
`define PMRS_OFS_FLAGS 8'h08
`define PMRS_OFS_VECTOR 8'h0c
`define PMRS_OFS_STATUS 8'h10

`define PMRS_CTRL_SWBOR 2
`define PMRS_CTRL_SWPOR 3
`define PMRS_CTRL_REGOFF 4
`define PMRS_CTRL_SVE 6
`define PMRS_SVE_RESET 1'b1
`define PMRS_REGOFF_RESET 1'b0

`define PMRS_MODE_ACTIVE 2'h0
`define PMRS_MODE_LIGHT 2'h1
`define PMRS_MODE_STANDBY 2'h2
`define PMRS_MODE_DEEPSLEEP 2'h3

`define PMRS_FLAG_BOR 0
`define PMRS_FLAG_POR 1
`define PMRS_FLAG_SVS 2
`define PMRS_FLAG_DWAKE 3

`define PMRS_VEC_NONE 8'h00
`define PMRS_VEC_BOR 8'h02
`define PMRS_VEC_SVS 8'h04
`define PMRS_VEC_DWAKE 8'h06
`define PMRS_VEC_POR 8'h08

`define PMRS_LOAD_OFF 2'h0
`define PMRS_LOAD_LOW 2'h1
`define PMRS_LOAD_MID 2'h2
`define PMRS_LOAD_HIGH 2'h3

`define PMRS_RESP_OKAY 2'h0
`define PMRS_RESP_SLVERR 2'h2

`define PMRS_CLK_PERIOD_NS 4
`define PMRS_BOR_HOLD_NS 20
`define PMRS_POR_HOLD_NS 12
`define PMRS_BOR_HOLD_CYC ((`PMRS_BOR_HOLD_NS + `PMRS_CLK_PERIOD_NS - 1) / `PMRS_CLK_PERIOD_NS)
`define PMRS_POR_HOLD_CYC ((`PMRS_POR_HOLD_NS + `PMRS_CLK_PERIOD_NS - 1) / `PMRS_CLK_PERIOD_NS)

`endif

// >>> hdl/pmrs_pkg.sv
// types of the power supervision and reset sequencer.
// assumes the constants header for field widths only by convention.
package pmrs_pkg;

  typedef enum logic [5:0] {
    ST_BROWNOUT = 6'b000001,
    ST_POR = 6'b000010,
    ST_ACTIVE = 6'b000100,
    ST_LOWPOWER = 6'b001000,
    ST_DEEP_OFF = 6'b010000,
    ST_LP_RESET = 6'b100000
  } pmrs_fsm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pmrs_wreq_t;

  typedef struct packed {
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmrs_axil_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stab;
  } pmrs_sync_t;

  typedef struct packed {
    pmrs_fsm_t fsm;
    logic [2:0] hold;
    logic sve;
    logic regoff;
    logic [1:0] mode;
    logic deep_rtc;
    logic sve_entry;
    logic [3:0] flags;
    logic bor;
    logic por;
    logic clr;
    logic core_en;
    logic lp_reg_en;
    logic sv_en;
    logic rtc_en;
    logic wake_en;
    logic [1:0] load;
  } pmrs_core_t;

endpackage : pmrs_pkg

// >>> hdl/pmrs_sync.sv
// two-flop synchroniser for the supervisor and brownout comparator levels.
// assumes the comparator outputs are quasi-static levels.
`timescale 1ns/100ps
module pmrs_sync import pmrs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);
  pmrs_sync_t q;
  pmrs_sync_t n;

  // the first stage feeds only the second stage
  always_comb begin
    n.meta = async_i;
    n.stab = q.meta;
  end

  // resets to "supply not ok" so the device starts in brownout reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sync_o = q.stab;
endmodule : pmrs_sync

// >>> hdl/pmrs_axil.sv
// axi4-lite slave front end: holds address and data, issues one-cycle
// strobes to the register file and registers every answer.
// assumes one write and one read outstanding at a time.
`timescale 1ns/100ps
`include "pmrs_consts.svh"
module pmrs_axil import pmrs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic wr_en_o,
  output pmrs_wreq_t wr_req_o,
  input wire logic wr_err_i,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  pmrs_axil_t q;
  pmrs_axil_t n;

  assign wr_en_o = q.aw_full && q.w_full && !q.bvalid;
  assign wr_req_o = '{addr: q.awaddr, data: q.wdata, strb: q.wstrb};
  assign rd_en_o = s_axi_arvalid_i && q.arready;
  assign rd_addr_o = s_axi_araddr_i;

  always_comb begin
    n = q;
    if (s_axi_awvalid_i && q.awready) begin
      n.aw_full = 1'b1;
      n.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      n.w_full = 1'b1;
      n.wdata = s_axi_wdata_i;
      n.wstrb = s_axi_wstrb_i;
    end
    if (wr_en_o) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_err_i ? `PMRS_RESP_SLVERR : `PMRS_RESP_OKAY;
    end else if (q.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    // no new write is taken until the previous response has gone
    n.awready = !n.aw_full && !n.bvalid;
    n.wready = !n.w_full && !n.bvalid;
    if (rd_en_o) begin
      n.rvalid = 1'b1;
      n.rdata = rd_data_i;
      n.rresp = rd_err_i ? `PMRS_RESP_SLVERR : `PMRS_RESP_OKAY;
    end else if (q.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
endmodule : pmrs_axil

// >>> hdl/pmrs_top.sv
// power supervision and reset sequencer: brownout/power-on/clear resets,
// deep-off modes, low-power reset state and sticky reset cause flags.
// assumes synchronous pin inputs and asynchronous comparator levels.
// Contract
// - supervisor on in all modes; software may drop it only in standby/deep modes
// - hold brownout reset at power-up until supervisor reports supply reached
// - deep-off modes switch the core regulator off entirely
// - deep-off entry keeps the supervisor enable held at the moment of entry
// - supply-drop wake from deep-off is flagged as supervisor reset
// - supply below power-down level resets the device completely
// - supply drop in deep-off with supervisor on enters low-power reset state
// - reset pin in low-power reset goes to brownout reset, restart on supply
// - brownout detector forces brownout reset until supply is sufficient
// - software brownout trigger causes brownout reset and sets its cause flag
// - brownout implies power-on reset and clear; power-on reset implies clear
// - brownout flag clears by software write or by vector read
// - software power-on trigger causes power-on reset and sets its cause flag
// - power-on flag clears by software write or by vector read
// - both software trigger bits clear themselves
// - regulator load follows mode, clocks and debug activity automatically
// - rtc deep-off keeps the low-power clock regulator supplying the clock domain
// - regulator-off request turns standby/deep-sleep entry into deep-off entry
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "pmrs_consts.svh"
module pmrs_top import pmrs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic svs_ok_i,
  input wire logic bod_ok_i,
  input wire logic rst_pin_n_i,
  input wire logic wake_event_i,
  input wire logic clk_active_i,
  input wire logic fast_clock_i,
  input wire logic debug_active_i,
  output logic brownout_reset_o,
  output logic poweron_reset_o,
  output logic power_up_clear_o,
  output logic core_regulator_en_o,
  output logic low_power_clock_regulator_en_o,
  output logic supervisor_en_o,
  output logic rtc_domain_en_o,
  output logic wake_enable_o,
  output logic [1:0] regulator_load_o
);
  pmrs_core_t q;
  pmrs_core_t n;
  logic [1:0] sync_lvl;
  logic svs_ok_s;
  logic bod_ok_s;
  logic wr_en;
  pmrs_wreq_t wr_req;
  logic wr_err;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic ctrl_wr;
  logic mode_wr;
  logic flags_wr;
  logic sw_bor;
  logic sw_por;
  logic sv_drop;
  logic [7:0] vec_code;
  logic [3:0] vec_bit;

  pmrs_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({bod_ok_i, svs_ok_i}),
    .sync_o(sync_lvl)
  );
  assign svs_ok_s = sync_lvl[0];
  assign bod_ok_s = sync_lvl[1];

  pmrs_axil u_axil (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_req_o(wr_req),
    .wr_err_i(wr_err),
    .rd_en_o(rd_en),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  assign ctrl_wr = wr_en && wr_req.addr == `PMRS_OFS_CTRL && wr_req.strb[0];
  assign mode_wr = wr_en && wr_req.addr == `PMRS_OFS_MODE && wr_req.strb[0];
  assign flags_wr = wr_en && wr_req.addr == `PMRS_OFS_FLAGS && wr_req.strb[0];
  // triggers act only while the cpu runs
  assign sw_bor = ctrl_wr && wr_req.data[`PMRS_CTRL_SWBOR] && q.fsm == ST_ACTIVE;
  assign sw_por = ctrl_wr && wr_req.data[`PMRS_CTRL_SWPOR] && q.fsm == ST_ACTIVE;
  assign sv_drop = q.sv_en && !svs_ok_s;
  assign wr_err = !(wr_req.addr inside {`PMRS_OFS_CTRL, `PMRS_OFS_MODE, `PMRS_OFS_FLAGS,
                                        `PMRS_OFS_VECTOR, `PMRS_OFS_STATUS});

  // reset cause vector reports the highest-priority pending cause
  always_comb begin
    vec_code = `PMRS_VEC_NONE;
    vec_bit = 4'h0;
    if (q.flags[`PMRS_FLAG_BOR]) begin
      vec_code = `PMRS_VEC_BOR;
      vec_bit[`PMRS_FLAG_BOR] = 1'b1;
    end else if (q.flags[`PMRS_FLAG_SVS]) begin
      vec_code = `PMRS_VEC_SVS;
      vec_bit[`PMRS_FLAG_SVS] = 1'b1;
    end else if (q.flags[`PMRS_FLAG_DWAKE]) begin
      vec_code = `PMRS_VEC_DWAKE;
      vec_bit[`PMRS_FLAG_DWAKE] = 1'b1;
    end else if (q.flags[`PMRS_FLAG_POR]) begin
      vec_code = `PMRS_VEC_POR;
      vec_bit[`PMRS_FLAG_POR] = 1'b1;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (rd_addr)
      `PMRS_OFS_CTRL: begin
        // trigger bits always read as zero
        rd_data[`PMRS_CTRL_SVE] = q.sve;
        rd_data[`PMRS_CTRL_REGOFF] = q.regoff;
      end
      `PMRS_OFS_MODE: rd_data[1:0] = q.mode;
      `PMRS_OFS_FLAGS: rd_data[3:0] = q.flags;
      `PMRS_OFS_VECTOR: rd_data[7:0] = vec_code;
      `PMRS_OFS_STATUS: rd_data[9:0] = {q.load, svs_ok_s, bod_ok_s, q.fsm};
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    n = q;
    n.hold = (q.hold != 3'h0) ? q.hold - 3'h1 : 3'h0;
    if (ctrl_wr) begin
      n.sve = wr_req.data[`PMRS_CTRL_SVE];
      n.regoff = wr_req.data[`PMRS_CTRL_REGOFF];
    end
    // clears first; every set below overrides a clear in the same cycle
    if (flags_wr) begin
      n.flags = q.flags & ~wr_req.data[3:0];
    end
    if (rd_en && rd_addr == `PMRS_OFS_VECTOR) begin
      n.flags = n.flags & ~vec_bit;
    end
    case (q.fsm)
      ST_BROWNOUT: begin
        n.sve = `PMRS_SVE_RESET;
        n.regoff = `PMRS_REGOFF_RESET;
        n.mode = `PMRS_MODE_ACTIVE;
        if (q.hold == 3'h0 && svs_ok_s && bod_ok_s) begin
          n.fsm = ST_ACTIVE;
        end
      end
      ST_POR: begin
        if (q.hold == 3'h0) begin
          n.fsm = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sw_bor) begin
          n.fsm = ST_BROWNOUT;
          n.hold = 3'(`PMRS_BOR_HOLD_CYC);
          n.flags[`PMRS_FLAG_BOR] = 1'b1;
        end else if (sv_drop || !rst_pin_n_i) begin
          n.fsm = ST_BROWNOUT;
          n.hold = 3'(`PMRS_BOR_HOLD_CYC);
          n.flags[`PMRS_FLAG_SVS] = sv_drop | n.flags[`PMRS_FLAG_SVS];
        end else if (sw_por) begin
          n.fsm = ST_POR;
          n.hold = 3'(`PMRS_POR_HOLD_CYC);
          n.flags[`PMRS_FLAG_POR] = 1'b1;
        end else if (mode_wr && wr_req.data[1:0] != `PMRS_MODE_ACTIVE) begin
          n.mode = wr_req.data[1:0];
          if (q.regoff && wr_req.data[1:0] != `PMRS_MODE_LIGHT) begin
            n.fsm = ST_DEEP_OFF;
            n.deep_rtc = wr_req.data[1:0] == `PMRS_MODE_STANDBY;
            n.sve_entry = q.sve;
          end else begin
            n.fsm = ST_LOWPOWER;
          end
        end
      end
      ST_LOWPOWER: begin
        if (sv_drop || !rst_pin_n_i) begin
          n.fsm = ST_BROWNOUT;
          n.hold = 3'(`PMRS_BOR_HOLD_CYC);
          n.flags[`PMRS_FLAG_SVS] = sv_drop | n.flags[`PMRS_FLAG_SVS];
        end else if (wake_event_i) begin
          n.fsm = ST_ACTIVE;
          n.mode = `PMRS_MODE_ACTIVE;
        end
      end
      ST_DEEP_OFF: begin
        if (q.sve_entry && !svs_ok_s) begin
          n.fsm = ST_LP_RESET;
          n.flags[`PMRS_FLAG_SVS] = 1'b1;
        end else if (wake_event_i || !rst_pin_n_i) begin
          // leaving deep-off restarts the core from brownout reset
          n.fsm = ST_BROWNOUT;
          n.hold = 3'(`PMRS_BOR_HOLD_CYC);
          n.flags[`PMRS_FLAG_DWAKE] = 1'b1;
        end
      end
      ST_LP_RESET: begin
        if (!rst_pin_n_i) begin
          n.fsm = ST_BROWNOUT;
          n.hold = 3'(`PMRS_BOR_HOLD_CYC);
        end
      end
      default: begin
        n.fsm = ST_BROWNOUT;
        n.hold = 3'(`PMRS_BOR_HOLD_CYC);
      end
    endcase
    // the brownout detector overrides every state, supervisor or not
    if (!bod_ok_s) begin
      n.fsm = ST_BROWNOUT;
      n.hold = 3'(`PMRS_BOR_HOLD_CYC);
    end
    n.bor = n.fsm == ST_BROWNOUT;
    n.por = n.bor || n.fsm == ST_POR;
    n.clr = n.por;
    n.core_en = !(n.fsm inside {ST_DEEP_OFF, ST_LP_RESET});
    n.lp_reg_en = n.fsm == ST_DEEP_OFF && n.deep_rtc;
    n.rtc_en = !(n.fsm == ST_LP_RESET || (n.fsm == ST_DEEP_OFF && !n.deep_rtc));
    n.wake_en = n.fsm != ST_LP_RESET;
    case (n.fsm)
      ST_LP_RESET: n.sv_en = 1'b0;
      ST_DEEP_OFF: n.sv_en = n.sve_entry;
      ST_LOWPOWER: n.sv_en = n.sve || n.mode == `PMRS_MODE_LIGHT;
      default: n.sv_en = 1'b1;
    endcase
    // load setting is derived, never written by software
    if (!n.core_en) begin
      n.load = `PMRS_LOAD_OFF;
    end else if (debug_active_i || fast_clock_i) begin
      n.load = `PMRS_LOAD_HIGH;
    end else if (n.fsm == ST_ACTIVE || clk_active_i) begin
      n.load = `PMRS_LOAD_MID;
    end else begin
      n.load = `PMRS_LOAD_LOW;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.fsm <= ST_BROWNOUT;
      q.hold <= 3'(`PMRS_BOR_HOLD_CYC);
      q.sve <= `PMRS_SVE_RESET;
      q.regoff <= `PMRS_REGOFF_RESET;
      q.bor <= 1'b1;
      q.por <= 1'b1;
      q.clr <= 1'b1;
      q.core_en <= 1'b1;
      q.sv_en <= 1'b1;
      q.rtc_en <= 1'b1;
      q.wake_en <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign brownout_reset_o = q.bor;
  assign poweron_reset_o = q.por;
  assign power_up_clear_o = q.clr;
  assign core_regulator_en_o = q.core_en;
  assign low_power_clock_regulator_en_o = q.lp_reg_en;
  assign supervisor_en_o = q.sv_en;
  assign rtc_domain_en_o = q.rtc_en;
  assign wake_enable_o = q.wake_en;
  assign regulator_load_o = q.load;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence swbor_write_s;
    sw_bor;
  endsequence
  sequence bor_taken_s;
    brownout_reset_o && q.flags[`PMRS_FLAG_BOR];
  endsequence
  sequence swpor_write_s;
    sw_por && !sw_bor && bod_ok_s && svs_ok_s && rst_pin_n_i;
  endsequence
  sequence por_taken_s;
    poweron_reset_o && !brownout_reset_o && q.flags[`PMRS_FLAG_POR] ##1
      (poweron_reset_o && !brownout_reset_o)[*2];
  endsequence

  bor_cascade_a: assert property (
    brownout_reset_o |-> poweron_reset_o && power_up_clear_o)
    else $error("brownout reset without power-on reset or clear");
  por_clear_a: assert property (poweron_reset_o |-> power_up_clear_o)
    else $error("power-on reset without clear");
  deep_off_core_a: assert property (
    q.fsm inside {ST_DEEP_OFF, ST_LP_RESET} |-> !core_regulator_en_o)
    else $error("core regulator on in deep-off");
  lp_reset_entry_a: assert property (
    q.fsm == ST_DEEP_OFF && q.sve_entry && !svs_ok_s && bod_ok_s |=>
      q.fsm == ST_LP_RESET && !supervisor_en_o && !rtc_domain_en_o && !wake_enable_o &&
      q.flags[`PMRS_FLAG_SVS])
    else $error("low-power reset state not entered");
  lp_reset_pin_a: assert property (
    q.fsm == ST_LP_RESET && !rst_pin_n_i |=> brownout_reset_o)
    else $error("reset pin ignored in low-power reset");
  bod_hold_a: assert property (!bod_ok_s |=> brownout_reset_o ##1 brownout_reset_o)
    else $error("brownout reset not held");
  bor_release_a: assert property (
    $fell(brownout_reset_o) |-> $past(svs_ok_s) && $past(bod_ok_s))
    else $error("brownout reset released with supply low");
  swbor_flag_a: assert property (swbor_write_s |=> bor_taken_s)
    else $error("software brownout trigger not taken");
  swpor_flag_a: assert property (swpor_write_s |=> por_taken_s)
    else $error("software power-on trigger not taken");
  active_supervisor_a: assert property (q.fsm == ST_ACTIVE |-> supervisor_en_o)
    else $error("supervisor off in active mode");
  regoff_entry_a: assert property (
    q.fsm == ST_ACTIVE && mode_wr && q.regoff && wr_req.data[1:0] == `PMRS_MODE_STANDBY &&
      !sw_bor && !sw_por && !sv_drop && rst_pin_n_i && bod_ok_s |=>
      q.fsm == ST_DEEP_OFF && low_power_clock_regulator_en_o)
    else $error("regulator-off standby entry missed deep-off");
endmodule : pmrs_top

// >>> sim/power_supervision_reset_seq_tb.sv
// self-checking bench for the power supervision and reset sequencer.
// assumes the top module answers axi4-lite and syncs comparators in two flops.
`timescale 1ns/100ps
`include "pmrs_consts.svh"
module power_supervision_reset_seq_tb;
  logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic awready, wready, arready, svs_ok, bod_ok, pin_n, wake, clk_act, fast, dbg;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, load;
  logic bor, por, clr, core_en, lp_en, sv_en, rtc_en, wake_en;
  int errors, n_compared, cyc;

  pmrs_top u_pmrs_top (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .svs_ok_i(svs_ok), .bod_ok_i(bod_ok), .rst_pin_n_i(pin_n),
    .wake_event_i(wake), .clk_active_i(clk_act), .fast_clock_i(fast),
    .debug_active_i(dbg), .brownout_reset_o(bor), .poweron_reset_o(por),
    .power_up_clear_o(clr), .core_regulator_en_o(core_en),
    .low_power_clock_regulator_en_o(lp_en), .supervisor_en_o(sv_en),
    .rtc_domain_en_o(rtc_en), .wake_enable_o(wake_en), .regulator_load_o(load));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task results;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // master holds each channel until its own handshake edge; bready and rready
  // stay up after the first transfer so back-to-back calls never toggle them
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, `PMRS_RESP_OKAY});
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    chk({30'h0, rresp}, {30'h0, resp});
  endtask : axi_rd

  // waits for brownout reset to reach a level under a bounded count
  task wait_bor(input logic want);
    int n;
    n = 0;
    while (bor !== want && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, bor}, {31'h0, want});
  endtask : wait_bor

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, wake, fast, dbg} = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {svs_ok, bod_ok, pin_n, clk_act} = 4'b0111;
    errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // supply still low: reset must stay up
    repeat (20) @(posedge clk_i);
    chk({31'h0, bor}, 32'h1);
    svs_ok <= 1'b1;
    wait_bor(1'b0);
    chk({30'h0, load}, {30'h0, `PMRS_LOAD_MID});
    axi_rd(`PMRS_OFS_CTRL, `PMRS_RESP_OKAY);
    chk(rd & 32'h5c, 32'h40);
    axi_rd(8'h40, `PMRS_RESP_SLVERR);
    chk(rd, 32'h0);
    axi_wr(`PMRS_OFS_FLAGS, 32'hf);
    // software brownout cascades into power-on reset and clear
    axi_wr(`PMRS_OFS_CTRL, 32'h44);
    chk({29'h0, bor, por, clr}, 32'h7);
    wait_bor(1'b0);
    axi_rd(`PMRS_OFS_CTRL, `PMRS_RESP_OKAY);
    chk(rd & 32'h0c, 32'h0);
    axi_rd(`PMRS_OFS_FLAGS, `PMRS_RESP_OKAY);
    chk(rd & 32'hf, 32'h1);
    axi_rd(`PMRS_OFS_VECTOR, `PMRS_RESP_OKAY);
    chk(rd & 32'hff, {24'h0, `PMRS_VEC_BOR});
    axi_rd(`PMRS_OFS_FLAGS, `PMRS_RESP_OKAY);
    chk(rd & 32'hf, 32'h0);
    // software power-on: no brownout, clear follows
    axi_wr(`PMRS_OFS_CTRL, 32'h48);
    chk({29'h0, bor, por, clr}, 32'h3);
    repeat (8) @(posedge clk_i);
    axi_rd(`PMRS_OFS_FLAGS, `PMRS_RESP_OKAY);
    chk(rd & 32'hf, 32'h2);
    axi_wr(`PMRS_OFS_FLAGS, 32'h2);
    axi_rd(`PMRS_OFS_FLAGS, `PMRS_RESP_OKAY);
    chk(rd & 32'hf, 32'h0);
    // standby with regulator off: rtc deep-off, then supply drop
    axi_wr(`PMRS_OFS_CTRL, 32'h50);
    axi_wr(`PMRS_OFS_MODE, {30'h0, `PMRS_MODE_STANDBY});
    repeat (3) @(posedge clk_i);
    chk({28'h0, core_en, lp_en, load}, {28'h0, 2'b01, `PMRS_LOAD_OFF});
    svs_ok <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({28'h0, core_en, sv_en, rtc_en, wake_en}, 32'h0);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, bor}, 32'h1);
    pin_n <= 1'b1;
    svs_ok <= 1'b1;
    wait_bor(1'b0);
    axi_rd(`PMRS_OFS_VECTOR, `PMRS_RESP_OKAY);
    chk(rd & 32'hff, {24'h0, `PMRS_VEC_SVS});
    // deep sleep with supervisor off: full deep-off, wake event
    axi_wr(`PMRS_OFS_CTRL, 32'h10);
    axi_wr(`PMRS_OFS_MODE, {30'h0, `PMRS_MODE_DEEPSLEEP});
    repeat (3) @(posedge clk_i);
    chk({29'h0, core_en, lp_en, sv_en}, 32'h0);
    wake <= 1'b1;
    repeat (3) @(posedge clk_i);
    wake <= 1'b0;
    wait_bor(1'b0);
    axi_rd(`PMRS_OFS_VECTOR, `PMRS_RESP_OKAY);
    chk(rd & 32'hff, {24'h0, `PMRS_VEC_DWAKE});
    // brownout detector overrides everything in active
    bod_ok <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk({31'h0, bor}, 32'h1);
    repeat (10) @(posedge clk_i);
    chk({31'h0, bor}, 32'h1);
    bod_ok <= 1'b1;
    wait_bor(1'b0);
    // supply drop while active resets completely
    svs_ok <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk({29'h0, bor, por, clr}, 32'h7);
    svs_ok <= 1'b1;
    wait_bor(1'b0);
    // light mode keeps the supervisor on; load follows clocks and debug
    axi_wr(`PMRS_OFS_MODE, {30'h0, `PMRS_MODE_LIGHT});
    clk_act <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({29'h0, sv_en, load}, {29'h0, 1'b1, `PMRS_LOAD_LOW});
    dbg <= 1'b1;
    wake <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({29'h0, bor, load}, {29'h0, 1'b0, `PMRS_LOAD_HIGH});
    results();
  end
endmodule : power_supervision_reset_seq_tb
